// *** core/id_io_regs.sv ***
`timescale 1ns/1ps
module id_io_regs #(
    parameter int MEAS_CYCLES = id_io_regs_pkg::MEAS_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // register access from ulpi command decoder
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_hit_o,
    // carkit status side
    input wire logic carkit_irq_en_i,
    input wire logic carkit_code_rd_i,
    output logic [2:0] carkit_code_o,
    output logic carkit_done_o,
    output logic meas_latch_o,
    input wire logic latch_rd_i,
    // analog measurement
    input wire logic [2:0] meas_code_pin_i,
    output logic meas_run_o,
    // mode inputs
    input wire logic serial_mode_i,
    input wire logic serial_tx_enable_i,
    input wire logic audio_mode_i,
    // controls to analog
    output logic alt_int_o,
    output logic line_pair_swap_o,
    output logic serial_route_swap_o,
    output logic speaker_swap_o,
    output logic dplus_detect_pullup_en_o,
    output logic dminus_detect_pullup_en_o,
    output logic [1:0] supply_sel_o
);
    // ==========================================
    // registers and decode
    logic [7:0] id_reg;
    logic [7:0] id_next;
    logic [7:0] io_reg;
    logic [7:0] io_next;
    logic [2:0] code_reg;
    logic done_reg;
    logic latch_reg;
    logic [1:0] ser_sel_reg;
    logic [2:0] code_sync;
    logic meas_busy;
    logic meas_finish;
    logic [7:0] id_view;
    logic [7:0] rdata_next;
    logic hit_id;
    logic hit_io;
    logic vendor_hit;
    logic wr_id;
    logic set_id;
    logic clr_id;
    logic wr_io;
    logic set_io;
    logic clr_io;
    logic rd_id;
    logic irq_en;
    logic done_rise;
    logic go_start;
    logic [1:0] supply_next;

    assign vendor_hit = (reg_addr_i >= id_io_regs_pkg::ADDR_VENDOR_LO) &&
                        (reg_addr_i <= id_io_regs_pkg::ADDR_VENDOR_HI);
    assign hit_id = (reg_addr_i >= id_io_regs_pkg::ADDR_ID_MEAS) &&
                    (reg_addr_i <= id_io_regs_pkg::ADDR_ID_MEAS_CLR);
    assign hit_io = (reg_addr_i >= id_io_regs_pkg::ADDR_IO_PWR) &&
                    (reg_addr_i <= id_io_regs_pkg::ADDR_IO_PWR_CLR);
    assign wr_id = reg_wr_i && (reg_addr_i == id_io_regs_pkg::ADDR_ID_MEAS);
    assign set_id = reg_wr_i && (reg_addr_i == id_io_regs_pkg::ADDR_ID_MEAS_SET);
    assign clr_id = reg_wr_i && (reg_addr_i == id_io_regs_pkg::ADDR_ID_MEAS_CLR);
    assign wr_io = reg_wr_i && (reg_addr_i == id_io_regs_pkg::ADDR_IO_PWR);
    assign set_io = reg_wr_i && (reg_addr_i == id_io_regs_pkg::ADDR_IO_PWR_SET);
    assign clr_io = reg_wr_i && (reg_addr_i == id_io_regs_pkg::ADDR_IO_PWR_CLR);
    assign rd_id = reg_rd_i && hit_id;

    // ==========================================
    // write, set and clear
    always_comb begin
        id_next = id_reg;
        if (wr_id) begin
            id_next = reg_wdata_i & id_io_regs_pkg::ID_MEAS_WMASK;
        end else if (set_id) begin
            id_next = id_reg | (reg_wdata_i & id_io_regs_pkg::ID_MEAS_WMASK);
        end else if (clr_id) begin
            id_next = id_reg & ~(reg_wdata_i & id_io_regs_pkg::ID_MEAS_WMASK);
        end
        // start self-clears on completion
        if (meas_finish) begin
            id_next[id_io_regs_pkg::GO_BIT] = 1'b0;
        end
    end

    always_comb begin
        io_next = io_reg;
        if (wr_io) begin
            io_next = reg_wdata_i & id_io_regs_pkg::IO_PWR_WMASK;
        end else if (set_io) begin
            io_next = io_reg | (reg_wdata_i & id_io_regs_pkg::IO_PWR_WMASK);
        end else if (clr_io) begin
            io_next = io_reg & ~(reg_wdata_i & id_io_regs_pkg::IO_PWR_WMASK);
        end
    end

    // ==========================================
    // measurement
    assign go_start = id_reg[id_io_regs_pkg::GO_BIT] && !meas_busy && !meas_finish;
    assign irq_en = id_reg[id_io_regs_pkg::IRQ_EN_BIT] | carkit_irq_en_i;
    assign done_rise = meas_finish && !done_reg;

    id_meas_timer #(
        .CYCLES(MEAS_CYCLES)
    ) u_timer (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .start_i(go_start),
        .busy_o(meas_busy),
        .finish_o(meas_finish)
    );

    sync2 #(
        .W(3)
    ) u_code_sync (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .d_i(meas_code_pin_i),
        .q_o(code_sync)
    );

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            id_reg <= id_io_regs_pkg::ID_MEAS_RESET;
            io_reg <= id_io_regs_pkg::IO_PWR_RESET;
            code_reg <= id_io_regs_pkg::RID_0_OHM;
        end else begin
            id_reg <= id_next;
            io_reg <= io_next;
            if (meas_finish) begin
                code_reg <= code_sync;
            end
        end
    end

    // done: set wins over read clear; carkit read has no effect
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            done_reg <= 1'b0;
        end else if (meas_finish) begin
            done_reg <= 1'b1;
        end else if (rd_id) begin
            done_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            latch_reg <= 1'b0;
        end else if (done_rise && irq_en) begin
            latch_reg <= 1'b1;
        end else if (latch_rd_i) begin
            latch_reg <= 1'b0;
        end
    end

    // ==========================================
    // read data
    assign id_view = {1'b0, id_reg[6:4], done_reg, code_reg};
    always_comb begin
        rdata_next = 8'h00;
        if (hit_id) begin
            rdata_next = id_view;
        end else if (hit_io) begin
            rdata_next = io_reg;
        end
    end

    // ==========================================
    // supply selection
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ser_sel_reg <= id_io_regs_pkg::IO_PWR_RESET[3:2];
        end else if (serial_mode_i && serial_tx_enable_i) begin
            ser_sel_reg <= io_reg[id_io_regs_pkg::SER_SEL_LSB +: 2];
        end
    end

    always_comb begin
        if (audio_mode_i) begin
            supply_next = id_io_regs_pkg::SUPPLY_3V3;
        end else if (serial_mode_i) begin
            supply_next = ser_sel_reg;
        end else begin
            supply_next = io_reg[id_io_regs_pkg::USB_SEL_LSB +: 2];
        end
    end

    // ==========================================
    // registered outputs
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
            reg_hit_o <= 1'b0;
            carkit_code_o <= 3'h0;
            carkit_done_o <= 1'b0;
            meas_latch_o <= 1'b0;
            meas_run_o <= 1'b0;
            alt_int_o <= 1'b0;
            line_pair_swap_o <= 1'b0;
            serial_route_swap_o <= 1'b0;
            speaker_swap_o <= 1'b0;
            dplus_detect_pullup_en_o <= 1'b0;
            dminus_detect_pullup_en_o <= 1'b0;
            supply_sel_o <= id_io_regs_pkg::SUPPLY_3V3;
        end else begin
            reg_rdata_o <= rdata_next;
            reg_hit_o <= reg_rd_i && vendor_hit && (hit_id || hit_io);
            carkit_code_o <= code_reg;
            carkit_done_o <= done_reg;
            meas_latch_o <= latch_reg;
            meas_run_o <= meas_busy;
            alt_int_o <= done_rise && irq_en;
            line_pair_swap_o <= io_reg[id_io_regs_pkg::SWAP_BIT];
            serial_route_swap_o <= io_reg[id_io_regs_pkg::SWAP_BIT] && serial_mode_i;
            speaker_swap_o <= 1'b0;
            dplus_detect_pullup_en_o <= io_reg[id_io_regs_pkg::DP_PU_BIT] | serial_mode_i;
            dminus_detect_pullup_en_o <= io_reg[id_io_regs_pkg::DM_PU_BIT] | serial_mode_i;
            supply_sel_o <= supply_next;
        end
    end
endmodule // id_io_regs

// *** include/id_io_regs_pkg.sv ***
package id_io_regs_pkg;
    // ==========================================
    // register addresses
    localparam logic [5:0] ADDR_ID_MEAS = 6'h36;
    localparam logic [5:0] ADDR_ID_MEAS_SET = 6'h37;
    localparam logic [5:0] ADDR_ID_MEAS_CLR = 6'h38;
    localparam logic [5:0] ADDR_IO_PWR = 6'h39;
    localparam logic [5:0] ADDR_IO_PWR_SET = 6'h3a;
    localparam logic [5:0] ADDR_IO_PWR_CLR = 6'h3b;
    localparam logic [5:0] ADDR_VENDOR_LO = 6'h30;
    localparam logic [5:0] ADDR_VENDOR_HI = 6'h3f;
    // ==========================================
    // field positions
    localparam int CODE_LSB = 0;
    localparam int DONE_BIT = 3;
    localparam int GO_BIT = 4;
    localparam int SPARE_BIT = 5;
    localparam int IRQ_EN_BIT = 6;
    localparam int SWAP_BIT = 1;
    localparam int SER_SEL_LSB = 2;
    localparam int DP_PU_BIT = 4;
    localparam int DM_PU_BIT = 5;
    localparam int USB_SEL_LSB = 6;
    // ==========================================
    // writable masks and reset values
    localparam logic [7:0] ID_MEAS_WMASK = 8'h70;
    localparam logic [7:0] IO_PWR_WMASK = 8'hfe;
    localparam logic [7:0] ID_MEAS_RESET = 8'h00;
    localparam logic [7:0] IO_PWR_RESET = 8'h04;
    // ==========================================
    // supply codes
    localparam logic [1:0] SUPPLY_3V3 = 2'h0;
    // ==========================================
    // resistance codes
    localparam logic [2:0] RID_0_OHM = 3'h0;
    localparam logic [2:0] RID_75_OHM = 3'h1;
    localparam logic [2:0] RID_100K = 3'h2;
    localparam logic [2:0] RID_440K = 3'h4;
    localparam logic [2:0] RID_FLOAT = 3'h5;
    localparam logic [2:0] RID_ERROR = 3'h7;
    // ==========================================
    // timing
    localparam int CLK_HZ = 40000000;
    localparam int MEAS_TIME_NS = 282000;
    localparam int MEAS_CYCLES = (MEAS_TIME_NS / 1000) * (CLK_HZ / 1000000);
endpackage

// *** core/id_meas_timer.sv ***
`timescale 1ns/1ps
module id_meas_timer #(
    parameter int CYCLES = 11280
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // control
    input wire logic start_i,
    output logic busy_o,
    output logic finish_o
);
    logic [15:0] count_reg;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_reg <= 16'h0000;
            busy_o <= 1'b0;
            finish_o <= 1'b0;
        end else begin
            finish_o <= 1'b0;
            if (start_i && !busy_o) begin
                count_reg <= 16'(CYCLES - 1);
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (count_reg == 16'h0000) begin
                    busy_o <= 1'b0;
                    finish_o <= 1'b1;
                end else begin
                    count_reg <= count_reg - 16'h0001;
                end
            end
        end
    end
endmodule // id_meas_timer

// *** core/sync2.sv ***
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule // sync2

// *** dv/link_model.sv ***
`timescale 1ns/1ps
module link_model (
    // clock
    input wire logic ref_clk_i,
    // register access to the device
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [5:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_hit_i
);
    // ==========================================
    // idle bus at time zero
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 6'h00;
        reg_wdata_o = 8'h00;
    end

    // ==========================================
    // one immediate register access, answer one cycle later
    task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic h);
        logic id_reg;
        id_reg = (a >= 6'h36) && (a <= 6'h38);
        @(posedge ref_clk_i);
        reg_wr_o <= w;
        reg_rd_o <= !w;
        reg_addr_o <= a;
        reg_wdata_o <= id_reg ? (d & 8'hdf) : d;
        @(posedge ref_clk_i);
        reg_wr_o <= 1'b0;
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
        #1;
        q = reg_rdata_i;
        h = reg_hit_i;
    endtask
endmodule // link_model

// *** dv/id_io_regs_assertions.sv ***
`timescale 1ns/1ps
module id_io_regs_assertions #(
    parameter int MEAS_CYCLES = 20
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // register access
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_hit_o,
    // measurement and status
    input wire logic carkit_code_rd_i,
    input wire logic carkit_done_o,
    input wire logic latch_rd_i,
    input wire logic meas_latch_o,
    input wire logic meas_run_o,
    input wire logic alt_int_o,
    // modes and controls
    input wire logic serial_mode_i,
    input wire logic audio_mode_i,
    input wire logic line_pair_swap_o,
    input wire logic serial_route_swap_o,
    input wire logic speaker_swap_o,
    input wire logic dplus_detect_pullup_en_o,
    input wire logic dminus_detect_pullup_en_o,
    input wire logic [1:0] supply_sel_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // ==========================================
    // helpers
    wire logic in_map = (reg_addr_i >= 6'h36) && (reg_addr_i <= 6'h3b);
    logic [15:0] run_len_reg;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) run_len_reg <= 16'h0;
        else if (meas_run_o) run_len_reg <= run_len_reg + 16'h1;
        else run_len_reg <= 16'h0;
    end
    // ==========================================
    // checks
    hit_decode_a: assert property (reg_rd_i |=> reg_hit_o == $past(in_map))
        else $error("hit flag wrong");
    unmapped_zero_a: assert property (reg_rd_i && !in_map |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    speaker_fixed_a: assert property (speaker_swap_o == 1'b0)
        else $error("speaker pins swapped");
    route_swap_a: assert property (serial_route_swap_o |-> line_pair_swap_o)
        else $error("route swap without line swap");
    pullup_force_a: assert property ($past(serial_mode_i) && !$past(reset_i)
        |-> dplus_detect_pullup_en_o && dminus_detect_pullup_en_o)
        else $error("pullups off in serial mode");
    audio_supply_a: assert property ($past(audio_mode_i) && !$past(reset_i)
        |-> supply_sel_o == 2'h0)
        else $error("audio supply not 3.3");
    alt_pulse_a: assert property (alt_int_o |=> !alt_int_o)
        else $error("alt int longer than a cycle");
    meas_len_a: assert property ($fell(meas_run_o)
        |-> run_len_reg >= MEAS_CYCLES - 1 && run_len_reg <= MEAS_CYCLES + 1)
        else $error("measurement length wrong");
    // status copy lags the flag by one cycle, so look two cycles on
    done_keep_a: assert property (carkit_code_rd_i && carkit_done_o && !reg_rd_i
        && !$past(reg_rd_i) && !meas_run_o |=> ##1 carkit_done_o)
        else $error("carkit read cleared done");
    done_clear_a: assert property (reg_rd_i && reg_addr_i == 6'h36 && !meas_run_o
        |-> ##[1:2] !carkit_done_o)
        else $error("done not cleared by read");
    latch_clear_a: assert property (latch_rd_i && !meas_run_o && !alt_int_o
        |=> ##1 !meas_latch_o)
        else $error("latch not cleared");
    go_start_a: assert property (reg_wr_i && reg_addr_i == 6'h37 && reg_wdata_i[4]
        |-> ##[1:3] meas_run_o)
        else $error("measurement not started");
endmodule // id_io_regs_assertions

bind id_io_regs id_io_regs_assertions #(.MEAS_CYCLES(MEAS_CYCLES)) checks (.*);

// *** dv/id_io_regs_tb.sv ***
`timescale 1ns/1ps
module id_io_regs_tb;
    // ==========================================
    // signals
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic reg_wr_i, reg_rd_i, reg_hit_o, h, seen;
    logic [5:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, q;
    logic carkit_irq_en_i = 1'b0, carkit_code_rd_i = 1'b0, latch_rd_i = 1'b0;
    logic serial_mode_i = 1'b0, serial_tx_enable_i = 1'b0, audio_mode_i = 1'b0;
    logic [2:0] meas_code_pin_i = 3'h0, carkit_code_o;
    logic [1:0] supply_sel_o;
    logic carkit_done_o, meas_latch_o, meas_run_o, alt_int_o, line_pair_swap_o;
    logic serial_route_swap_o, speaker_swap_o, dplus_detect_pullup_en_o, dminus_detect_pullup_en_o;
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
    int bad_count = 0, compares = 0, cycles = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    id_io_regs #(.MEAS_CYCLES(20)) dut (.*);
    link_model link (.ref_clk_i(ref_clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
        .reg_hit_i(reg_hit_o));
    // ==========================================
    // tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        link.access(1'b0, a, 8'h00, q, h);
        chk(q, exp, "read data");
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        link.access(1'b1, a, d, q, h);
    endtask
    task automatic settle;
        repeat (3) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic meas(output logic s);
        s = 1'b0;
        repeat (60) begin
            @(posedge ref_clk_i);
            #1;
            if (alt_int_o === 1'b1) s = 1'b1;
        end
    endtask
    task automatic conclude;
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            conclude();
        end
    end
    // ==========================================
    // tests
    initial begin
        repeat (20) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            rd(6'h36 + 6'(i), 8'h00);
            chk({7'h0, h}, 8'h01, "hit");
            rd(6'h39 + 6'(i), 8'h04);
            chk({7'h0, h}, 8'h01, "hit");
        end
        rd(6'h30, 8'h00);
        chk({7'h0, h}, 8'h00, "hit");
        $display("test reset values done");
        wr(6'h39, 8'hff);
        rd(6'h3b, 8'hfe);
        wr(6'h3b, 8'h0c);
        rd(6'h3a, 8'hf2);
        wr(6'h3a, 8'h04);
        rd(6'h39, 8'hf6);
        chk({6'h0, dplus_detect_pullup_en_o, dminus_detect_pullup_en_o}, 8'h03, "pu");
        chk({6'h0, supply_sel_o}, 8'h03, "usb supply");
        $display("test set and clear done");
        for (int i = 0; i < 4; i++) begin
            wr(6'h39, {2'(i), 2'b00, 2'(3 - i), 2'b10});
            settle();
            chk({6'h0, supply_sel_o}, {6'h0, 2'(i)}, "usb supply");
            @(posedge ref_clk_i);
            serial_mode_i <= 1'b1;
            serial_tx_enable_i <= 1'b1;
            settle();
            chk({6'h0, supply_sel_o}, {6'h0, 2'(3 - i)}, "serial supply");
            chk({4'h0, dplus_detect_pullup_en_o, dminus_detect_pullup_en_o,
                serial_route_swap_o, line_pair_swap_o}, 8'h0f, "serial pins");
            @(posedge ref_clk_i);
            serial_mode_i <= 1'b0;
            serial_tx_enable_i <= 1'b0;
            audio_mode_i <= 1'b1;
            settle();
            chk({5'h0, supply_sel_o, speaker_swap_o}, 8'h00, "audio");
            @(posedge ref_clk_i);
            audio_mode_i <= 1'b0;
        end
        serial_mode_i <= 1'b1;
        reset_i <= 1'b1;
        @(posedge ref_clk_i);
        serial_mode_i <= 1'b0;
        @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd(6'h39, 8'h04);
        $display("test modes done");
        @(posedge ref_clk_i);
        meas_code_pin_i <= 3'h5;
        wr(6'h36, 8'h40);
        wr(6'h37, 8'h10);
        meas(seen);
        chk({7'h0, seen}, 8'h01, "alt int");
        chk({6'h0, meas_latch_o, carkit_done_o}, 8'h03, "latch done");
        @(posedge ref_clk_i);
        carkit_code_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        carkit_code_rd_i <= 1'b0;
        settle();
        chk({4'h0, carkit_done_o, carkit_code_o}, 8'h0d, "carkit");
        rd(6'h36, 8'h4d);
        rd(6'h36, 8'h45);
        @(posedge ref_clk_i);
        latch_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        latch_rd_i <= 1'b0;
        settle();
        chk({7'h0, meas_latch_o}, 8'h00, "latch");
        wr(6'h38, 8'h40);
        for (int k = 0; k < 6; k++) begin
            @(posedge ref_clk_i);
            meas_code_pin_i <= codes[k];
            carkit_irq_en_i <= k[0];
            wr(6'h37, 8'h10);
            meas(seen);
            chk({7'h0, seen}, {7'h0, k[0]}, "or enable");
            rd(6'h36, {5'h01, codes[k]});
        end
        $display("test measurement done");
        conclude();
    end
endmodule // id_io_regs_tb
